// ==== design/ssf_regs.svh ====
// Register offsets, field positions and reset values of the serial status flag block
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
`define SSF_ADDR_STATUS_ONE 6'h00
`define SSF_ADDR_DATA_PORT 6'h04
`define SSF_ADDR_CONTROL_TWO 6'h08
`define SSF_ADDR_CONTROL_THREE 6'h0C
`define SSF_ADDR_MODE 6'h10
`define SSF_STATUS_RESET 8'hC0
`define SSF_C2_TX_DONE_IRQ_ENABLE 6
`define SSF_C2_RIE 5
`define SSF_C2_TX_ON 3
`define SSF_C2_BREAK 0
`define SSF_C3_RX_NINTH 7
`define SSF_C3_TX_NINTH 6
`define SSF_C3_OVERRUN_IRQ_ENABLE 3
`define SSF_MODE_NINE_BIT 3
`define SSF_MODE_IDLE_SEL 2
`define SSF_MODE_PARITY_ON 1
`define SSF_MODE_PARITY_ODD 0
`define SSF_IDLE_CHAR_EIGHT 4'hA
`define SSF_IDLE_CHAR_NINE 4'hB
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2
`endif

// ==== design/ssf_pkg.sv ====
// Types shared by the serial status flag block and its bench
package ssf_pkg;
  // Status register one, field order equals bit order 7 down to 0
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic transmit_done_flag;
    logic rx_buffer_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic parity_error_flag;
  } ssf_status_type;
  // Character handed over by the receive shifter
  typedef struct packed {
    logic [8:0] data;
    logic parity_bit;
    logic stop_bit;
  } ssf_rx_char_type;
endpackage

// ==== design/ssf_status_flags.sv ====
// Status register one flags, their clear sequences and an AXI4-Lite slave
//
// The implementer's own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ssf_regs.svh"
module ssf_status_flags (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Receive shifter side
  input wire logic rxd_line,
  input wire logic rx_bit_tick,
  input wire logic rx_start_strobe,
  input wire logic [6:0] rx_start_samples,
  input wire logic rx_bit_strobe,
  input wire logic [2:0] rx_bit_samples,
  input wire logic rx_char_ready,
  input wire ssf_pkg::ssf_rx_char_type rx_char,
  // Transmit shifter side
  input wire logic tx_load,
  input wire logic tx_active,
  output logic [8:0] tx_char,
  output logic tx_buffer_full,
  output logic tx_on,
  output logic break_queue_bit,
  output logic nine_bit_select,
  // Interrupt request
  output logic irq_request
);

  ssf_pkg::ssf_status_type st;
  ssf_pkg::ssf_status_type arm;
  logic [5:0] aw_addr;
  logic [7:0] w_byte;
  logic aw_held, w_held, w_lane0;
  logic tx_done_irq_enable, rx_full_irq_enable, overrun_irq_enable;
  logic tx_ninth, idle_count_select, parity_check_on, parity_odd;
  logic [8:0] rx_buf;
  logic got_data, got_c3, tx_queued, noise_acc, in_frame, idle_armed;
  logic [3:0] idle_cnt;
  logic wr_do, ar_take, status_rd, data_rd, c3_rd, data_wr, c2_wr;
  logic te_rise, sbk_set, tx_buffer_empty_flag_clear, tc_clear, tc_set, rx_buffer_full_flag_clear;
  logic rx_take, noise_now, ferr_now, perr_now, idle_hit;
  logic [3:0] idle_target;
  // Reset image of the status register, split below for the two transmit flags only
  localparam ssf_pkg::ssf_status_type status_reset = `SSF_STATUS_RESET;

  // Write side: address and data are held separately, either may come first
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_do = aw_held && w_held && !bvalid;
  assign ar_take = arvalid && arready;
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `SSF_RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      if (aw_addr > `SSF_ADDR_MODE || aw_addr[1:0] != 2'h0) begin
        bresp <= `SSF_RESP_SLVERR;
      end else begin
        bresp <= `SSF_RESP_OKAY;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Access strobes; a write with lane 0 disabled has no side effect
  assign status_rd = ar_take && araddr == `SSF_ADDR_STATUS_ONE;
  assign data_rd = ar_take && araddr == `SSF_ADDR_DATA_PORT;
  assign c3_rd = ar_take && araddr == `SSF_ADDR_CONTROL_THREE;
  assign data_wr = wr_do && w_lane0 && aw_addr == `SSF_ADDR_DATA_PORT;
  assign c2_wr = wr_do && w_lane0 && aw_addr == `SSF_ADDR_CONTROL_TWO;
  assign te_rise = c2_wr && w_byte[`SSF_C2_TX_ON] && !tx_on;
  assign sbk_set = c2_wr && w_byte[`SSF_C2_BREAK] && tx_on;

  // Read data, decoded on the accepted address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `SSF_RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rresp <= `SSF_RESP_OKAY;
      rdata <= 32'h0000_0000;
      if (araddr == `SSF_ADDR_STATUS_ONE) begin
        rdata[7:0] <= st;
      end else if (araddr == `SSF_ADDR_DATA_PORT) begin
        rdata[7:0] <= rx_buf[7:0];
      end else if (araddr == `SSF_ADDR_CONTROL_TWO) begin
        rdata[`SSF_C2_TX_DONE_IRQ_ENABLE] <= tx_done_irq_enable;
        rdata[`SSF_C2_RIE] <= rx_full_irq_enable;
        rdata[`SSF_C2_TX_ON] <= tx_on;
        rdata[`SSF_C2_BREAK] <= break_queue_bit;
      end else if (araddr == `SSF_ADDR_CONTROL_THREE) begin
        rdata[`SSF_C3_RX_NINTH] <= rx_buf[8];
        rdata[`SSF_C3_TX_NINTH] <= tx_ninth;
        rdata[`SSF_C3_OVERRUN_IRQ_ENABLE] <= overrun_irq_enable;
      end else if (araddr == `SSF_ADDR_MODE) begin
        rdata[`SSF_MODE_NINE_BIT] <= nine_bit_select;
        rdata[`SSF_MODE_IDLE_SEL] <= idle_count_select;
        rdata[`SSF_MODE_PARITY_ON] <= parity_check_on;
        rdata[`SSF_MODE_PARITY_ODD] <= parity_odd;
      end else begin
        rresp <= `SSF_RESP_SLVERR;
      end
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Control registers; the status register has no write path at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_irq_enable <= 1'b0;
      rx_full_irq_enable <= 1'b0;
      tx_on <= 1'b0;
      break_queue_bit <= 1'b0;
      tx_ninth <= 1'b0;
      overrun_irq_enable <= 1'b0;
      nine_bit_select <= 1'b0;
      idle_count_select <= 1'b0;
      parity_check_on <= 1'b0;
      parity_odd <= 1'b0;
    end else if (wr_do && w_lane0) begin
      if (aw_addr == `SSF_ADDR_CONTROL_TWO) begin
        tx_done_irq_enable <= w_byte[`SSF_C2_TX_DONE_IRQ_ENABLE];
        rx_full_irq_enable <= w_byte[`SSF_C2_RIE];
        tx_on <= w_byte[`SSF_C2_TX_ON];
        break_queue_bit <= w_byte[`SSF_C2_BREAK];
      end else if (aw_addr == `SSF_ADDR_CONTROL_THREE) begin
        tx_ninth <= w_byte[`SSF_C3_TX_NINTH];
        overrun_irq_enable <= w_byte[`SSF_C3_OVERRUN_IRQ_ENABLE];
      end else if (aw_addr == `SSF_ADDR_MODE) begin
        nine_bit_select <= w_byte[`SSF_MODE_NINE_BIT];
        idle_count_select <= w_byte[`SSF_MODE_IDLE_SEL];
        parity_check_on <= w_byte[`SSF_MODE_PARITY_ON];
        parity_odd <= w_byte[`SSF_MODE_PARITY_ODD];
      end
    end
  end

  // Transmit buffer; the ninth bit is taken as it stands at the data write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_char <= 9'h000;
    end else if (data_wr) begin
      tx_char <= {tx_ninth, w_byte};
    end
  end
  assign tx_buffer_full = !st.tx_buffer_empty_flag;

  // Preamble or break waiting for the shifter; keeps done low until it starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_queued <= 1'b0;
    end else if (te_rise || sbk_set) begin
      tx_queued <= 1'b1;
    end else if (tx_active) begin
      tx_queued <= 1'b0;
    end
  end

  // Receive error evaluation for the character being assembled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      noise_acc <= 1'b0;
    end else if (rx_start_strobe) begin
      noise_acc <= |rx_start_samples && !(&rx_start_samples);
    end else if (rx_char_ready) begin
      noise_acc <= 1'b0;
    end else if (rx_bit_strobe && |rx_bit_samples && !(&rx_bit_samples)) begin
      noise_acc <= 1'b1;
    end
  end
  assign noise_now = noise_acc || (rx_bit_strobe && |rx_bit_samples && !(&rx_bit_samples));
  assign ferr_now = !rx_char.stop_bit;
  assign perr_now = parity_check_on && (parity_odd ^ rx_char.parity_bit ^ ^rx_char.data[7:0]
    ^ (nine_bit_select && rx_char.data[8]));
  assign rx_take = rx_char_ready && !st.rx_buffer_full_flag;

  // Received character holding register; an overrun leaves it untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf <= 9'h000;
    end else if (rx_take) begin
      rx_buf <= rx_char.data;
    end
  end

  // Idle detection: count high bit times, held at zero in frame if select is 1
  assign idle_target = nine_bit_select ? `SSF_IDLE_CHAR_NINE : `SSF_IDLE_CHAR_EIGHT;
  assign idle_hit = idle_armed && idle_cnt == idle_target;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame <= 1'b0;
      idle_cnt <= 4'h0;
    end else begin
      if (rx_start_strobe) begin
        in_frame <= 1'b1;
      end else if (rx_char_ready) begin
        in_frame <= 1'b0;
      end
      if (!rxd_line) begin
        idle_cnt <= 4'h0;
      end else if (idle_count_select && (in_frame || rx_char_ready)) begin
        idle_cnt <= 4'h0;
      end else if (rx_bit_tick && idle_cnt != idle_target) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
    end
  end

  // Idle may report once per loaded character
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_armed <= 1'b0;
    end else if (rx_take) begin
      idle_armed <= 1'b1;
    end else if (idle_hit) begin
      idle_armed <= 1'b0;
    end
  end

  // Clear qualifiers; only flags captured by the last status read may clear
  assign tx_buffer_empty_flag_clear = arm.tx_buffer_empty_flag && data_wr;
  assign tc_clear = arm.transmit_done_flag && (data_wr || te_rise || sbk_set);
  assign rx_buffer_full_flag_clear = arm.rx_buffer_full_flag && (nine_bit_select ?
    ((data_rd || got_data) && (c3_rd || got_c3)) : data_rd);
  assign tc_set = st.tx_buffer_empty_flag && !tx_buffer_empty_flag_clear && !tx_active && !tx_queued
    && !tc_clear;

  // Arming snapshot and the nine-bit read tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm <= 8'h00;
      got_data <= 1'b0;
      got_c3 <= 1'b0;
    end else if (status_rd) begin
      arm <= st;
      got_data <= 1'b0;
      got_c3 <= 1'b0;
    end else begin
      if (data_rd) begin
        got_data <= 1'b1;
        arm.idle_flag <= 1'b0;
        arm.overrun_flag <= 1'b0;
        arm.noise_flag <= 1'b0;
        arm.framing_error_flag <= 1'b0;
        arm.parity_error_flag <= 1'b0;
      end
      if (c3_rd) begin
        got_c3 <= 1'b1;
      end
      if (rx_buffer_full_flag_clear) begin
        arm.rx_buffer_full_flag <= 1'b0;
      end
      if (tx_buffer_empty_flag_clear) begin
        arm.tx_buffer_empty_flag <= 1'b0;
      end
      if (tc_clear) begin
        arm.transmit_done_flag <= 1'b0;
      end
    end
  end

  // Transmit flags; empty set has priority over its clear, a done clear wins over the done set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.tx_buffer_empty_flag <= status_reset.tx_buffer_empty_flag;
      st.transmit_done_flag <= status_reset.transmit_done_flag;
    end else begin
      if (tx_load) begin
        st.tx_buffer_empty_flag <= 1'b1;
      end else if (tx_buffer_empty_flag_clear) begin
        st.tx_buffer_empty_flag <= 1'b0;
      end
      if (tc_set) begin
        st.transmit_done_flag <= 1'b1;
      end else if (tc_clear || tx_active || tx_queued) begin
        st.transmit_done_flag <= 1'b0;
      end
    end
  end

  // Receive flags; errors are written with the character they describe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st.rx_buffer_full_flag <= 1'b0;
      st.idle_flag <= 1'b0;
      st.overrun_flag <= 1'b0;
      st.noise_flag <= 1'b0;
      st.framing_error_flag <= 1'b0;
      st.parity_error_flag <= 1'b0;
    end else begin
      if (rx_take) begin
        st.rx_buffer_full_flag <= 1'b1;
        st.noise_flag <= noise_now;
        st.framing_error_flag <= ferr_now;
        st.parity_error_flag <= perr_now;
      end else begin
        if (rx_buffer_full_flag_clear) begin
          st.rx_buffer_full_flag <= 1'b0;
        end
        if (arm.noise_flag && data_rd) begin
          st.noise_flag <= 1'b0;
        end
        if (arm.framing_error_flag && data_rd) begin
          st.framing_error_flag <= 1'b0;
        end
        if (arm.parity_error_flag && data_rd) begin
          st.parity_error_flag <= 1'b0;
        end
      end
      if (rx_char_ready && st.rx_buffer_full_flag) begin
        st.overrun_flag <= 1'b1;
      end else if (arm.overrun_flag && data_rd) begin
        st.overrun_flag <= 1'b0;
      end
      if (idle_hit) begin
        st.idle_flag <= 1'b1;
      end else if (arm.idle_flag && data_rd) begin
        st.idle_flag <= 1'b0;
      end
    end
  end

  // Interrupt request is a plain level from enabled flags
  assign irq_request = (tx_done_irq_enable && st.transmit_done_flag)
    || (rx_full_irq_enable && st.rx_buffer_full_flag)
    || (overrun_irq_enable && st.overrun_flag);

  default clocking ssf_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_status_write_inert:
  assert property (wr_do && aw_addr == `SSF_ADDR_STATUS_ONE && st.tx_buffer_empty_flag
    |=> st.tx_buffer_empty_flag) else $error("status write disturbed a flag");
  a_tx_empty_set:
  assert property (tx_load |=> st.tx_buffer_empty_flag) else $error("tx empty not set");
  a_tx_empty_hold:
  assert property (st.tx_buffer_empty_flag && !arm.tx_buffer_empty_flag
    |=> st.tx_buffer_empty_flag) else $error("tx empty cleared without arming");
  a_tx_done_clear:
  assert property (arm.transmit_done_flag && data_wr |=> !st.transmit_done_flag)
    else $error("tx done not cleared by data write");
  a_rx_full_eight:
  assert property (arm.rx_buffer_full_flag && !nine_bit_select && data_rd && !rx_char_ready
    |=> !st.rx_buffer_full_flag) else $error("rx full not cleared");
  a_rx_full_nine:
  assert property (arm.rx_buffer_full_flag && nine_bit_select && data_rd && !got_c3
    |=> st.rx_buffer_full_flag) else $error("rx full cleared before third control read");
  a_overrun_drop:
  assert property (rx_char_ready && st.rx_buffer_full_flag
    |=> st.overrun_flag && rx_buf == $past(rx_buf)) else $error("overrun not handled");
  a_noise_with_char:
  assert property (rx_take && noise_now |=> st.noise_flag && st.rx_buffer_full_flag)
    else $error("noise not recorded");
  a_idle_once:
  assert property (!idle_armed && !st.idle_flag |=> !st.idle_flag)
    else $error("idle set without new character");
  a_irq_tx_done:
  assert property (tx_done_irq_enable && st.transmit_done_flag |-> irq_request)
    else $error("missing tx done interrupt");

endmodule

// ==== testbench/ssf_far_node.sv ====
// Far-side model: receive framer on the line and a transmit shifter
`timescale 1ns/100ps
module ssf_far_node (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controls seen from the block
  input wire logic tx_buffer_full,
  input wire logic tx_on,
  input wire logic break_queue_bit,
  input wire logic nine_bit_select,
  // Receive shifter side
  output logic rxd_line,
  output logic rx_bit_tick,
  output logic rx_start_strobe,
  output logic [6:0] rx_start_samples,
  output logic rx_bit_strobe,
  output logic [2:0] rx_bit_samples,
  output logic rx_char_ready,
  output ssf_pkg::ssf_rx_char_type rx_char,
  // Transmit shifter side
  output logic tx_load,
  output logic tx_active
);
  logic [1:0] tick_count;
  logic [4:0] busy;
  logic [3:0] wait_count;
  logic tx_on_seen;
  initial begin
    rxd_line = 1'h1;
    rx_start_strobe = 1'h0;
    rx_start_samples = 7'h7F;
    rx_bit_strobe = 1'h0;
    rx_bit_samples = 3'h7;
    rx_char_ready = 1'h0;
    rx_char = '0;
  end
  // Baud tick runs free, one pulse every four cycles
  always_ff @(posedge aclk) begin
    tick_count <= aresetn ? tick_count + 2'h1 : 2'h0;
    rx_bit_tick <= aresetn && tick_count == 2'h2;
  end
  // Shifter takes the buffer late on purpose so flags can be read in between
  always_ff @(posedge aclk) begin
    tx_on_seen <= tx_on;
    tx_load <= 1'h0;
    wait_count <= tx_buffer_full ? wait_count + 4'(wait_count != 4'h9) : 4'h0;
    if (!aresetn) begin
      busy <= 5'h00;
    end else if (busy != 5'h00) begin
      busy <= busy - 5'h01;
    end else if (tx_buffer_full && wait_count == 4'h9) begin
      tx_load <= 1'h1;
      busy <= 5'h14;
    end else if (break_queue_bit || (tx_on && !tx_on_seen)) begin
      busy <= 5'h14; // Break or preamble keeps the shifter active
    end
  end
  assign tx_active = busy != 5'h00;
  // One frame: start, data bits LSB first, stop, then hand over the character
  task automatic send_char(input logic [8:0] d, input logic noisy, input logic stop,
                           input logic par);
    int n;
    logic b;
    n = nine_bit_select ? 9 : 8;
    @(posedge aclk iff rx_bit_tick);
    rxd_line <= 1'h0;
    @(posedge aclk iff rx_bit_tick);
    rx_start_strobe <= 1'h1;
    rx_start_samples <= noisy ? 7'h08 : 7'h00;
    for (int k = 0; k <= n; k++) begin
      b = (k == n) ? stop : d[k];
      rxd_line <= b;
      @(posedge aclk);
      rx_start_strobe <= 1'h0;
      rx_bit_strobe <= 1'h0;
      rx_start_samples <= 7'h7F;
      @(posedge aclk iff rx_bit_tick);
      rx_bit_strobe <= 1'h1;
      rx_bit_samples <= {3{b}};
    end
    rx_char_ready <= 1'h1;
    rx_char <= '{data: d, parity_bit: par, stop_bit: stop};
    @(posedge aclk);
    rx_char_ready <= 1'h0;
    rx_bit_strobe <= 1'h0;
    rx_bit_samples <= ~rx_bit_samples;
    rx_char <= ~rx_char; // Released value is not the last one
    rxd_line <= 1'h1;
  endtask
endmodule

// ==== testbench/ssf_status_flags_test.sv ====
// Self-checking bench of the serial status flag block
`timescale 1ns/100ps
`include "ssf_regs.svh"
module ssf_status_flags_test;
  localparam logic [5:0] st = `SSF_ADDR_STATUS_ONE;
  localparam logic [5:0] dp = `SSF_ADDR_DATA_PORT;
  localparam logic [5:0] c2 = `SSF_ADDR_CONTROL_TWO;
  localparam logic [5:0] c3 = `SSF_ADDR_CONTROL_THREE;
  localparam logic [5:0] md = `SSF_ADDR_MODE;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq_request, tx_load, tx_active;
  logic rxd_line, rx_bit_tick, rx_start_strobe, rx_bit_strobe, rx_char_ready;
  logic tx_buffer_full, tx_on, break_queue_bit, nine_bit_select;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] rx_start_samples;
  logic [2:0] rx_bit_samples;
  logic [8:0] tx_char;
  ssf_pkg::ssf_rx_char_type rx_char;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int fails = 0, compares = 0;
  logic [7:0] d;
  // Mode, data, noise/stop/parity, expected status
  logic [31:0] cases [3] = '{32'h02_07_04_F7, 32'h03_07_02_F0, 32'h03_06_02_F1};
  always #12.5 aclk = ~aclk;
  ssf_status_flags ssf_status_flags_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .rxd_line, .rx_bit_tick, .rx_start_strobe, .rx_start_samples,
    .rx_bit_strobe, .rx_bit_samples, .rx_char_ready, .rx_char, .tx_load, .tx_active, .tx_char,
    .tx_buffer_full, .tx_on, .break_queue_bit, .nine_bit_select, .irq_request);
  ssf_far_node far_node_i (.aclk, .aresetn, .tx_buffer_full, .tx_on, .break_queue_bit,
    .nine_bit_select, .rxd_line, .rx_bit_tick, .rx_start_strobe, .rx_start_samples,
    .rx_bit_strobe, .rx_bit_samples, .rx_char_ready, .rx_char, .tx_load, .tx_active);
  task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic timeout();
    fails++;
    finish_test();
  endtask
  // Wait, bounded, for an answer sampled high at a falling edge
  task automatic handshake(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      if (++n > 200) timeout();
    end while (s !== 1'h1);
    @(posedge aclk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic [1:0] resp);
    logic pa, pw, ta, tw;
    bq.push_back(resp);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    for (int n = 0; pa || pw; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      if (n > 200) timeout();
      @(posedge aclk);
      if (pa && ta === 1'h1) begin
        awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (pw && tw === 1'h1) begin
        wvalid <= 1'h0;
        pw = 1'h0;
      end
    end
    handshake(bvalid);
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] v, input logic [1:0] resp = 2'h0);
    rq.push_back({resp, 24'h0, v});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    handshake(arready);
    arvalid <= 1'h0;
    handshake(rvalid);
    rready <= 1'h0;
  endtask
  task automatic chk_irq(input logic e);
    @(negedge aclk);
    check({33'h0, irq_request}, {33'h0, e}, "irq");
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Monitor takes the oldest note whenever an answer is handed over
  always @(posedge aclk) begin
    if (rvalid && rready) check({rresp, rdata}, rq.pop_front(), "read");
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()}, "write");
  end
  initial begin
    void'($urandom(32'h743B));
    pause(8);
    aresetn <= 1'h1;
    rd(st, 8'hC0);
    wr(st, 8'hFF, 2'h0);
    rd(st, 8'hC0);
    wr(6'h14, 8'h01, 2'h2);
    rd(6'h02, 8'h00, 2'h2);
    // Transmit: data write after status read, shifter takes it later
    wr(c2, 8'h08, 2'h0);
    pause(40);
    rd(st, 8'hC0);
    d = 8'($urandom);
    wr(dp, d, 2'h0);
    check({25'h0, tx_char}, {26'h0, d}, "tx char");
    rd(st, 8'h00);
    pause(60);
    rd(st, 8'hC0);
    // Preamble by switching the transmitter back on, then a break
    wr(c2, 8'h00, 2'h0);
    pause(40);
    rd(st, 8'hC0);
    wr(c2, 8'h08, 2'h0);
    rd(st, 8'h80);
    pause(40);
    wr(c2, 8'h09, 2'h0);
    rd(st, 8'h80);
    wr(c2, 8'h08, 2'h0);
    pause(60);
    rd(st, 8'hC0);
    wr(c2, 8'h48, 2'h0);
    chk_irq(1'h1);
    wr(c2, 8'h08, 2'h0);
    chk_irq(1'h0);
    // Receive a clean random byte, idle only once
    d = 8'($urandom);
    far_node_i.send_char({1'h0, d}, 1'h0, 1'h1, 1'h0);
    pause(60);
    rd(st, 8'hF0);
    rd(dp, d);
    rd(st, 8'hC0);
    pause(80);
    rd(st, 8'hC0);
    // Error flags travel with their character
    for (int i = 0; i < 3; i++) begin
      wr(md, cases[i][31:24], 2'h0);
      far_node_i.send_char({1'h0, cases[i][23:16]}, cases[i][10], cases[i][9], cases[i][8]);
      pause(60);
      rd(st, cases[i][7:0]);
      rd(dp, cases[i][23:16]);
      rd(st, 8'hC0);
    end
    // Idle count start: after the start bit, then after the stop bit
    wr(md, 8'h00, 2'h0);
    far_node_i.send_char(9'h0FF, 1'h0, 1'h1, 1'h0);
    pause(16);
    rd(st, 8'hF0);
    rd(dp, 8'hFF);
    wr(md, 8'h04, 2'h0);
    far_node_i.send_char(9'h0FF, 1'h0, 1'h1, 1'h0);
    pause(16);
    rd(st, 8'hE0);
    pause(60);
    rd(dp, 8'hFF);
    rd(st, 8'hD0);
    rd(dp, 8'hFF);
    rd(st, 8'hC0);
    // Overrun drops the second character and its errors
    wr(md, 8'h00, 2'h0);
    wr(c3, 8'h08, 2'h0);
    far_node_i.send_char(9'h011, 1'h0, 1'h1, 1'h0);
    far_node_i.send_char(9'h022, 1'h1, 1'h0, 1'h0);
    pause(60);
    chk_irq(1'h1);
    rd(st, 8'hF8);
    rd(dp, 8'h11);
    rd(st, 8'hC0);
    chk_irq(1'h0);
    // Nine-bit: both data and control three must be read
    wr(c3, 8'h00, 2'h0);
    wr(md, 8'h08, 2'h0);
    wr(c2, 8'h28, 2'h0);
    far_node_i.send_char(9'h1A5, 1'h0, 1'h1, 1'h0);
    pause(60);
    chk_irq(1'h1);
    rd(st, 8'hF0);
    rd(dp, 8'hA5);
    chk_irq(1'h1);
    rd(c3, 8'h80);
    chk_irq(1'h0);
    rd(st, 8'hC0);
    pause(4);
    finish_test();
  end
endmodule
